/* File: fais_ctrl.v */
/*
 * Host-side controller that reads the flash identifier codes.
 * Software programs a selection and a sector group through a plain
 * register port; the block drives the flash pins, applies the high
 * voltage request on A9 or relies on in-system command entry, waits
 * the access time and captures the low (and optionally upper) byte.
 * Assumes an external driver turns a9HighVolt into the high level on A9
 * and that the in-system command sequence is issued elsewhere.
 */
// Design decisions made here: strobed register access and the register offsets.
// What this block does
// - Request high voltage on A9 before reading in that method.
// - Hold A6 low; set A3..A0 to the selected code pattern.
// - Put the sector group on A22..A15 for protection checks.
// - In-system mode reads without high voltage on any pin.
// - Read with chip enable low, output enable low, write high.
`timescale 1ns/1ns
`default_nettype none
`include "fais_defs.vh"
module fais_ctrl #(
    parameter ACC_CYC = `FAIS_ACC_CYC,
    parameter SETTLE_CYC = `FAIS_SETTLE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Register port
    input wire [3:0] cmdAddr,
    input wire [15:0] cmdWdata,
    input wire cmdWr,
    input wire cmdRd,
    output reg [15:0] cmdRdata,
    // Flash address and control
    output reg [22:0] flashAddr,
    output reg chipEnableN,
    output reg outputEnableN,
    output reg writeEnableN,
    output reg byteModeSelect,
    output reg a9HighVolt,
    // Flash data
    input wire [15:0] flashDqIn,
    output wire [15:0] flashDqOut,
    output wire flashDqOe,
    // Status
    output wire busy
);
    // ==========================================================
    // States
    localparam ST_IDLE = 2'h0;
    localparam ST_SETTLE = 2'h1;
    localparam ST_ACCESS = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [1:0] state;
    reg [2:0] sel;
    reg useHv;
    reg wordMode;
    reg [7:0] sector;
    reg [15:0] capData;
    reg done;
    reg [7:0] cnt;
    wire [15:0] dqSync;
    wire [3:0] lowAddr;
    wire a6Level;
    wire [2:0] next_sel;
    wire next_useHv;
    wire next_wordMode;

    // Host only reads; data pins are never driven
    assign flashDqOut = 16'h0000;
    assign flashDqOe = 1'b0;
    assign busy = (state != ST_IDLE);

    // ==========================================================
    // Input synchroniser and address pattern
    fais_sync #(
        .W(16)
    ) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(flashDqIn),
        .dout(dqSync)
    );

    fais_decode u_dec (
        .sel(next_sel),
        .lowAddr(lowAddr),
        .a6Level(a6Level)
    );

    // ==========================================================
    // Decoded results
    wire protFlag = capData[`FAIS_PROT_BIT];
    wire indLocked = capData[7];
    wire indTopPart = (capData[7:0] == `FAIS_IND_HI_LOCKED) ||
        (capData[7:0] == `FAIS_IND_HI_OPEN);
    wire indBotPart = (capData[7:0] == `FAIS_IND_LO_LOCKED) ||
        (capData[7:0] == `FAIS_IND_LO_OPEN);

    // ==========================================================
    // Register writes
    wire goWr = cmdWr && (cmdAddr == `FAIS_REG_CTRL) &&
        cmdWdata[`FAIS_CTRL_GO] && (state == ST_IDLE);

    // A go write starts with the fields it carries
    assign next_sel = goWr ?
        cmdWdata[`FAIS_CTRL_SEL_HI:`FAIS_CTRL_SEL_LO] : sel;
    assign next_useHv = goWr ? cmdWdata[`FAIS_CTRL_HV] : useHv;
    assign next_wordMode = goWr ? cmdWdata[`FAIS_CTRL_BYTE] : wordMode;

    always @(posedge mclk) begin
        if (!nrst) begin
            sel <= `FAIS_SEL_MAKER;
            useHv <= 1'b0;
            wordMode <= 1'b0;
            sector <= 8'h00;
        end else if (cmdWr && state == ST_IDLE) begin
            if (cmdAddr == `FAIS_REG_CTRL) begin
                sel <= cmdWdata[`FAIS_CTRL_SEL_HI:`FAIS_CTRL_SEL_LO];
                useHv <= cmdWdata[`FAIS_CTRL_HV];
                wordMode <= cmdWdata[`FAIS_CTRL_BYTE];
            end else if (cmdAddr == `FAIS_REG_SECT) begin
                sector <= cmdWdata[7:0];
            end
        end
    end

    // ==========================================================
    // Read sequencer
    always @(posedge mclk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            flashAddr <= 23'h000000;
            chipEnableN <= 1'b1;
            outputEnableN <= 1'b1;
            writeEnableN <= 1'b1;
            byteModeSelect <= 1'b0;
            a9HighVolt <= 1'b0;
            capData <= 16'h0000;
            done <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (goWr) begin
                        done <= 1'b0;
                        // Other address bits stay zero
                        flashAddr <= 23'h000000;
                        flashAddr[3:0] <= lowAddr;
                        flashAddr[6] <= a6Level;
                        if (next_sel == `FAIS_SEL_PROT) begin
                            flashAddr[22:15] <= sector;
                        end
                        byteModeSelect <= next_wordMode;
                        // High voltage only for that entry method
                        a9HighVolt <= next_useHv;
                        cnt <= 8'h00;
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    cnt <= cnt + 8'h01;
                    if (!a9HighVolt || cnt >= SETTLE_CYC[7:0] - 8'h01) begin
                        chipEnableN <= 1'b0;
                        outputEnableN <= 1'b0;
                        writeEnableN <= 1'b1;
                        cnt <= 8'h00;
                        state <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    cnt <= cnt + 8'h01;
                    // Covers access time plus two sync stages
                    if (cnt >= ACC_CYC[7:0] + 8'h01) begin
                        capData[7:0] <= dqSync[7:0];
                        if (byteModeSelect && sel != `FAIS_SEL_PROT &&
                                sel != `FAIS_SEL_IND) begin
                            capData[15:8] <= dqSync[15:8];
                        end else begin
                            capData[15:8] <= 8'h00;
                        end
                        chipEnableN <= 1'b1;
                        outputEnableN <= 1'b1;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    a9HighVolt <= 1'b0;
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Register reads, data one cycle later
    always @(posedge mclk) begin
        if (!nrst) begin
            cmdRdata <= 16'h0000;
        end else if (cmdRd) begin
            if (cmdAddr == `FAIS_REG_CTRL) begin
                cmdRdata <= {7'h00, wordMode, 1'b0, sel, 2'h0, useHv, 1'b0};
            end else if (cmdAddr == `FAIS_REG_SECT) begin
                cmdRdata <= {8'h00, sector};
            end else if (cmdAddr == `FAIS_REG_STAT) begin
                cmdRdata <= {14'h0000, done, busy};
            end else if (cmdAddr == `FAIS_REG_DATA) begin
                cmdRdata <= capData;
            end else if (cmdAddr == `FAIS_REG_PROT) begin
                cmdRdata <= {15'h0000, protFlag};
            end else if (cmdAddr == `FAIS_REG_IND) begin
                cmdRdata <= {13'h0000, indBotPart, indTopPart, indLocked};
            end else begin
                cmdRdata <= 16'h0000;
            end
        end else begin
            cmdRdata <= 16'h0000;
        end
    end
endmodule // fais_ctrl
`default_nettype wire

/* File: fais_defs.vh */
/*
 * Constants for the identifier read-out controller: code selections,
 * pin field positions, expected indicator values and bus timing counts.
 * Assumes a 10 MHz controller clock.
 */
`ifndef FAIS_DEFS_VH
`define FAIS_DEFS_VH

// ==========================================================
// Register map of the controller (word index on cmdAddr)
`define FAIS_REG_CTRL 4'h0
`define FAIS_REG_SECT 4'h1
`define FAIS_REG_STAT 4'h2
`define FAIS_REG_DATA 4'h3
`define FAIS_REG_PROT 4'h4
`define FAIS_REG_IND 4'h5

// ==========================================================
// Control register fields
`define FAIS_CTRL_GO 0
`define FAIS_CTRL_HV 1
`define FAIS_CTRL_SEL_LO 4
`define FAIS_CTRL_SEL_HI 6
`define FAIS_CTRL_BYTE 8

// ==========================================================
// Code selections
`define FAIS_SEL_MAKER 3'h0
`define FAIS_SEL_DEV1 3'h1
`define FAIS_SEL_DEV2 3'h2
`define FAIS_SEL_DEV3 3'h3
`define FAIS_SEL_PROT 3'h4
`define FAIS_SEL_IND 3'h5

// A3..A0 patterns for each selection
`define FAIS_LOW_MAKER 4'h0
`define FAIS_LOW_DEV1 4'h1
`define FAIS_LOW_DEV2 4'he
`define FAIS_LOW_DEV3 4'hf
`define FAIS_LOW_PROT 4'h2
`define FAIS_LOW_IND 4'h3

// ==========================================================
// Indicator byte values
`define FAIS_IND_HI_LOCKED 8'h98
`define FAIS_IND_HI_OPEN 8'h18
`define FAIS_IND_LO_LOCKED 8'h88
`define FAIS_IND_LO_OPEN 8'h08
`define FAIS_PROT_BIT 0

// ==========================================================
// Timing: access time and high-voltage settle time, ns
`define FAIS_CLK_NS 100
`define FAIS_ACC_NS 100
`define FAIS_SETTLE_NS 500
`define FAIS_ACC_CYC ((`FAIS_ACC_NS + `FAIS_CLK_NS - 1) / `FAIS_CLK_NS + 1)
`define FAIS_SETTLE_CYC ((`FAIS_SETTLE_NS + `FAIS_CLK_NS - 1) / `FAIS_CLK_NS)

`endif

/* File: fais_sync.v */
/*
 * Two-flop synchroniser for the flash data inputs.
 * Assumes inputs arrive asynchronously to mclk.
 */
`timescale 1ns/1ns
`default_nettype none
module fais_sync #(
    parameter W = 16
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Data
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] stage1;

    always @(posedge mclk) begin
        if (!nrst) begin
            stage1 <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // fais_sync
`default_nettype wire

/* File: fais_decode.v */
/*
 * Maps a code selection onto the low address pins A6 and A3..A0.
 * Pure combinational; assumes a selection from the defs header.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fais_defs.vh"
module fais_decode (
    // Selection
    input wire [2:0] sel,
    // Pin pattern
    output reg [3:0] lowAddr,
    output wire a6Level
);
    assign a6Level = 1'b0;

    always @* begin
        case (sel)
            `FAIS_SEL_MAKER: lowAddr = `FAIS_LOW_MAKER;
            `FAIS_SEL_DEV1: lowAddr = `FAIS_LOW_DEV1;
            `FAIS_SEL_DEV2: lowAddr = `FAIS_LOW_DEV2;
            `FAIS_SEL_DEV3: lowAddr = `FAIS_LOW_DEV3;
            `FAIS_SEL_PROT: lowAddr = `FAIS_LOW_PROT;
            `FAIS_SEL_IND: lowAddr = `FAIS_LOW_IND;
            default: lowAddr = `FAIS_LOW_MAKER;
        endcase
    end
endmodule // fais_decode
`default_nettype wire

/* File: fais_ctrl_monitor.sv */
/* Checker for the identifier read-out controller.
   Assumes binding to fais_ctrl, seeing only its ports. */
`timescale 1ns/1ns
`default_nettype none
module fais_ctrl_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Flash pins and status
    input wire logic [22:0] flashAddr,
    input wire logic chipEnableN,
    input wire logic outputEnableN,
    input wire logic writeEnableN,
    input wire logic a9HighVolt,
    input wire logic flashDqOe,
    input wire logic busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Pin levels
    chk_we_idle: assert property (writeEnableN && !flashDqOe)
        else $error("write or data drive active");
    chk_read_oe: assert property (
        !chipEnableN |-> !outputEnableN && busy)
        else $error("read levels wrong");
    chk_code_pins: assert property (!chipEnableN |-> !flashAddr[6] &&
        flashAddr[3:0] inside {4'h0, 4'h1, 4'he, 4'hf, 4'h2, 4'h3})
        else $error("code pins wrong");
    chk_unused_zero: assert property (!chipEnableN |->
        flashAddr[14:7] == 8'h0 && flashAddr[5:4] == 2'h0)
        else $error("unused address bits set");
    chk_sector_only: assert property (
        !chipEnableN && flashAddr[3:0] != 4'h2 |-> flashAddr[22:15] == 8'h0)
        else $error("sector bits outside check");
    // ==========================================================
    // High voltage sequence
    chk_hv_settle: assert property (
        $rose(a9HighVolt) |-> chipEnableN[*5])
        else $error("read before settle");
    chk_hv_held: assert property ($fell(chipEnableN) && a9HighVolt |->
        a9HighVolt[*4] ##1 chipEnableN)
        else $error("high voltage dropped in read");
    chk_hv_drop: assert property (
        $rose(chipEnableN) |=> !a9HighVolt)
        else $error("high voltage kept after read");
endmodule // fais_ctrl_monitor
bind fais_ctrl fais_ctrl_monitor i_mon (.mclk(mclk), .nrst(nrst),
    .flashAddr(flashAddr), .chipEnableN(chipEnableN),
    .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
    .a9HighVolt(a9HighVolt), .flashDqOe(flashDqOe), .busy(busy));
`default_nettype wire

/* File: fais_flash_model.sv */
/* Behavioural flash answering identifier reads.
   Assumes host pins straight from the controller. */
`timescale 1ns/1ns
`default_nettype none
module fais_flash_model #(
    parameter logic [39:0] ID = 40'hc33c5a6b7c // Arbitrary
) (
    // Host pins
    input wire logic [22:0] addr,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic byteSel,
    input wire logic hv,
    // Device state
    input wire logic inSys,
    input wire logic locked,
    input wire logic topGuard,
    input wire logic [7:0] protGroup,
    output logic [15:0] dq
);
    logic [7:0] code;
    logic [15:0] last = 16'h0;
    wire rdOn = !ceN && !oeN && weN;
    wire idMode = (hv || inSys) && !addr[6];
    wire idCode = addr[3:0] inside {4'h0, 4'h1, 4'he, 4'hf};
    // ==========================================================
    // Code chosen by A3..A0 alone
    always_comb begin
        case (addr[3:0])
            4'h0: code = ID[31:24];
            4'h1: code = ID[23:16];
            4'he: code = ID[15:8];
            4'hf: code = ID[7:0];
            4'h2: code = {7'h0, addr[22:15] == protGroup};
            4'h3: code = {locked, 2'h0, topGuard, 4'h8};
            default: code = ~last[7:0];
        endcase
        if (rdOn && !idMode)
            dq = addr[15:0] ^ 16'ha5a5;
        else if (rdOn)
            dq = {byteSel && idCode ? ID[39:32] : ~last[15:8], code};
        else
            dq = ~last;
    end
    // Released bus shows the inverse
    always @(posedge ceN) last <= dq;
endmodule // fais_flash_model
`default_nettype wire

/* File: fais_tb.sv */
/* Bench for the identifier read-out controller.
   Assumes the model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "fais_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    localparam logic [39:0] ID = 40'hc33c5a6b7c; // Arbitrary
    logic mclk = 0, nrst = 0, cmdWr = 0, cmdRd = 0, rdPend = 0;
    logic inSys = 0, locked = 0, topGuard = 0, w, pr;
    logic [3:0] cmdAddr = 0;
    logic [15:0] cmdWdata = 0, expd, cw, ev, ib;
    logic [7:0] protGroup = 0, sg;
    logic [2:0] s;
    wire [15:0] cmdRdata, dq;
    wire [22:0] flashAddr;
    wire ceN, oeN, weN, byteSel, hv, busy;
    logic [15:0] q[$];
    int num_errors = 0, checks_done = 0, k, n;
    always #50 mclk = ~mclk;
    fais_ctrl i_dut (.mclk(mclk), .nrst(nrst), .cmdAddr(cmdAddr),
        .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd),
        .cmdRdata(cmdRdata), .flashAddr(flashAddr), .chipEnableN(ceN),
        .outputEnableN(oeN), .writeEnableN(weN), .byteModeSelect(byteSel),
        .a9HighVolt(hv), .flashDqIn(dq), .flashDqOut(), .flashDqOe(),
        .busy(busy));
    fais_flash_model #(.ID(ID)) i_flash (.addr(flashAddr), .ceN(ceN),
        .oeN(oeN), .weN(weN), .byteSel(byteSel), .hv(hv), .inSys(inSys),
        .locked(locked), .topGuard(topGuard), .protGroup(protGroup), .dq(dq));
    // ==========================================================
    // Oldest note against each read answer
    always @(posedge mclk) begin
        if (rdPend) begin
            expd = q.pop_front();
            `CHK(cmdRdata, expd)
        end
        rdPend <= cmdRd;
    end
    task automatic bus(input logic wn, input logic [3:0] a,
        input logic [15:0] d);
        @(posedge mclk);
        cmdAddr <= a;
        cmdWdata <= d;
        cmdWr <= wn;
        cmdRd <= !wn;
        if (!wn) q.push_back(d);
        @(posedge mclk);
        cmdWr <= 0;
        cmdRd <= 0;
    endtask
    task automatic idle();
        n = 0;
        @(posedge mclk);
        while (busy !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        `CHK(busy, 1'b0)
    endtask
    function automatic logic [15:0] expv(input logic [2:0] sl,
        input logic wm, lk, tg, p);
        logic [7:0] lo;
        lo = sl == 3'h4 ? {7'h0, p} : lk ? (tg ? 8'h98 : 8'h88)
            : (tg ? 8'h18 : 8'h08);
        if (sl < 3'h4) lo = ID[8 * (3 - sl) +: 8];
        return {wm && sl < 3'h4 ? ID[39:32] : 8'h00, lo};
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // Every selection, both entry methods
    initial begin
        k = $urandom(32'hd212906a);
        repeat (20) @(posedge mclk);
        nrst <= 1;
        bus(0, `FAIS_REG_STAT, 16'h0);
        for (k = 0; k < 24; k++) begin
            s = k % 6;
            w = $urandom;
            sg = $urandom;
            pr = k[1];
            locked <= k[1];
            topGuard <= k[2];
            inSys <= k >= 18;
            protGroup <= pr ? sg : ~sg;
            bus(1, `FAIS_REG_SECT, {8'h0, sg});
            cw = {7'h0, w, 1'b0, s, 2'h0, k < 18, 1'b1};
            ev = expv(s, w, k[1], k[2], pr);
            ib = {13'h0, !k[2], k[2], pr};
            bus(1, `FAIS_REG_CTRL, cw);
            idle();
            `CHK(flashAddr[22:15], s == 3'h4 ? sg : 8'h0)
            `CHK(byteSel, w)
            bus(0, `FAIS_REG_CTRL, cw & 16'hfffe);
            bus(0, `FAIS_REG_SECT, {8'h0, sg});
            bus(0, `FAIS_REG_STAT, 16'h0002);
            bus(0, `FAIS_REG_DATA, ev);
            if (s == 3'h5) bus(0, `FAIS_REG_IND, ib);
            if (s == 3'h4) bus(0, `FAIS_REG_PROT, {15'h0, pr});
        end
        // Array read once in-system entry is gone; busy write ignored
        inSys <= 0;
        bus(1, `FAIS_REG_CTRL, 16'h0001);
        bus(1, `FAIS_REG_CTRL, 16'h0013);
        idle();
        bus(0, `FAIS_REG_DATA, 16'h00a5);
        bus(0, 4'hf, 16'h0);
        repeat (2) @(posedge mclk);
        print_verdict();
    end
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end
endmodule // tb
`default_nettype wire
